// >>> common/cise_pkg.sv
// Constants, opcodes and types shared by the instruction subset executor.
// Overview of operation
// - Clear-file writes zero to the addressed byte and sets zero flag; one cycle.
// - Access bit zero selects access bank; one selects bank register plus file field.
// - Extended set, access bit zero, field at most 5Fh: frame pointer plus field.
// - Complement-file inverts the byte, updates N and Z; d zero goes to accumulator.
// - Compare-skip leaves flags; on equality drops next word, or two if two-word.
// - Indexed move: two words; frame pointer plus 7-bit offsets; copy source byte.
// - Indexed move addresses reach the whole 000h to FFFh space.
// - Indexed move never writes program counter low or the three stack top bytes.
// - Indexed move source on an indirect register copies zero.
// - Indexed move destination on an indirect register writes nothing.
// - Literal push stores literal at frame pointer then decrements it; flags kept.
// - Watchdog-clear zeroes the watchdog counter and its postscaler.
package cise_pkg;

  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned INSTR_W = 16;

  // Operand addressing limits.
  localparam logic [7:0]  ACC_LIMIT = 8'h60;
  localparam logic [7:0]  EXT_LIMIT = 8'h5F;
  localparam logic [3:0]  SFR_BANK  = 4'hF;

  // Protected destinations of the indexed move.
  localparam logic [11:0] PCL_ADDR  = 12'hFF9;
  localparam logic [11:0] STACK_TOP_LOW_ADDR = 12'hFFD;
  localparam logic [11:0] STACK_TOP_HIGH_ADDR = 12'hFFE;
  localparam logic [11:0] STACK_TOP_UPPER_ADDR = 12'hFFF;

  // Indirect registers sit at F D8h..F EFh where the low three bits are 3 or more.
  localparam logic [7:0]  IND_MIN   = 8'hD8;
  localparam logic [7:0]  IND_MAX   = 8'hEF;
  localparam logic [2:0]  IND_SUB   = 3'h3;

  // Opcode patterns, compared against the upper bits of a word; watchdog-clear is compared against the whole word.
  localparam logic [6:0]  OP_CLEAR_FILE_OP   = 7'h35;
  localparam logic [5:0]  OP_COMPLEMENT_FILE_OP   = 6'h07;
  localparam logic [6:0]  OP_CPFS   = 7'h31;
  localparam logic [8:0]  OP_MOVS1  = 9'h1D7;
  localparam logic [3:0]  OP_MOVS2  = 4'hF;
  localparam logic [7:0]  OP_LITERAL_PUSH_OP  = 8'hAF;
  localparam logic [15:0] OP_WATCHDOG_CLEAR_OP = 16'h0004;
  localparam logic [3:0]  OP_2W_A   = 4'hC;
  localparam logic [5:0]  OP_2W_B   = 6'h3B;

  // Values after reset.
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [3:0]  BSR_RST   = 4'h0;
  localparam logic [11:0] FP_RST    = 12'h000;

  typedef enum logic [4:0] {
    S_DEC = 5'b00001,
    S_RMW = 5'b00010,
    S_WD2 = 5'b00100,
    S_SK1 = 5'b01000,
    S_SK2 = 5'b10000
  } cise_state_e;

  typedef enum logic [1:0] {
    RMW_COMPLEMENT_FILE_OP = 2'h1,
    RMW_CMP  = 2'h2
  } cise_rmw_e;

  typedef struct packed {
    logic timeout;
    logic powerdown;
    logic neg;
    logic zero;
  } cise_flags_s;

  localparam cise_flags_s FLAGS_RST = '{timeout: 1'b1, powerdown: 1'b1, neg: 1'b0, zero: 1'b0};

endpackage

// >>> rtl/cise_dmem.sv
// Data memory with a synchronous write port and a registered read port.
module cise_dmem #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 8
) (
  // Clock.
  input  wire logic          clk_i,
  // Read port.
  input  wire logic          rd_en_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [DW-1:0] rd_data_o,
  // Write port.
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i
);

  logic [DW-1:0] mem_q [2**AW];
  logic [DW-1:0] rd_q;

  // Read data holds until the next read, so a stalled second word still sees it.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_q <= mem_q[rd_addr_i];
    end
  end

  assign rd_data_o = rd_q;

endmodule

// >>> rtl/cise_exec.sv
// Decode and execute logic for a subset of the core instruction set.
module cise_exec #(
  parameter int unsigned WDT_W  = 8,
  parameter int unsigned POST_W = 16
) (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Instruction fetch path.
  input  wire logic [15:0]         instr_i,
  input  wire logic                instr_valid_i,
  output logic                     instr_ready_o,
  // Configuration and register loads.
  input  wire logic                ext_set_en_i,
  input  wire logic                load_acc_i,
  input  wire logic                load_bsr_i,
  input  wire logic                load_fp_i,
  input  wire logic [11:0]         load_val_i,
  // Watchdog events.
  input  wire logic                wdt_tick_i,
  input  wire logic                timeout_clr_i,
  input  wire logic                powerdown_clr_i,
  // Core state.
  output logic [7:0]               acc_o,
  output logic [3:0]               bank_select_reg_o,
  output logic [11:0]              frame_pointer_o,
  output cise_pkg::cise_flags_s    flags_o,
  output logic [WDT_W-1:0]         watchdog_counter_o,
  output logic [POST_W-1:0]        postscaler_o,
  // Echo of the last data memory write.
  output logic                     wr_seen_o,
  output logic [11:0]              wr_addr_o,
  output logic [7:0]               wr_data_o
);

  if (WDT_W < 1 || POST_W < 1 || WDT_W > 32 || POST_W > 32) begin : g_chk
    $error("cise_exec: watchdog widths must be 1 to 32");
  end

  cise_pkg::cise_state_e state_q, state_d;
  cise_pkg::cise_rmw_e   rmw_q, rmw_d;
  cise_pkg::cise_flags_s flags_q, flags_d;
  logic [7:0]            acc_q, acc_d;
  logic [3:0]            bsr_q, bsr_d;
  logic [11:0]           fp_q, fp_d;
  logic [11:0]           addr_q, addr_d;
  logic                  dest_q, dest_d;
  logic                  src_ind_q, src_ind_d;
  logic [WDT_W-1:0]      wdt_q, wdt_d;
  logic [POST_W-1:0]     post_q, post_d;
  logic                  seen_q;
  logic [11:0]           waddr_q;
  logic [7:0]            wdata_q;
  logic                  rd_en, wr_en, wdt_clr;
  logic [11:0]           rd_addr, wr_addr;
  logic [7:0]            wr_data, rd_data, comp;
  logic [7:0]            f_fld;
  logic [11:0]           eff_a, mv_src, mv_dst;
  logic                  take, dst_bad;
  logic                  is_clear_file_op, is_complement_file_op, is_cpfs, is_movs, is_push, is_wdt;

  // True when an address names one of the indirect addressing registers.
  function automatic logic is_ind(input logic [11:0] a);
    is_ind = (a[11:8] == cise_pkg::SFR_BANK) && (a[7:0] >= cise_pkg::IND_MIN)
           && (a[7:0] <= cise_pkg::IND_MAX) && (a[2:0] >= cise_pkg::IND_SUB);
  endfunction

  // A skipped word that opens a two-word instruction costs one more cycle.
  function automatic logic two_word(input logic [15:0] w);
    two_word = (w[15:12] == cise_pkg::OP_2W_A) || (w[15:10] == cise_pkg::OP_2W_B);
  endfunction

  // Decode of the word offered while the decoder is free.
  assign take    = (state_q == cise_pkg::S_DEC) && instr_valid_i;
  assign f_fld   = instr_i[7:0];
  assign is_clear_file_op = take && (instr_i[15:9] == cise_pkg::OP_CLEAR_FILE_OP);
  assign is_complement_file_op = take && (instr_i[15:10] == cise_pkg::OP_COMPLEMENT_FILE_OP);
  assign is_cpfs = take && (instr_i[15:9] == cise_pkg::OP_CPFS);
  assign is_movs = take && (instr_i[15:7] == cise_pkg::OP_MOVS1);
  assign is_push = take && (instr_i[15:8] == cise_pkg::OP_LITERAL_PUSH_OP);
  assign is_wdt  = take && (instr_i == cise_pkg::OP_WATCHDOG_CLEAR_OP);

  // Byte operand address; the 12-bit sums cover the whole data space.
  always_comb begin
    if (instr_i[8]) begin
      eff_a = {bsr_q, f_fld};
    end else if (ext_set_en_i && (f_fld <= cise_pkg::EXT_LIMIT)) begin
      eff_a = fp_q + {4'h0, f_fld};
    end else if (f_fld < cise_pkg::ACC_LIMIT) begin
      eff_a = {4'h0, f_fld};
    end else begin
      eff_a = {cise_pkg::SFR_BANK, f_fld};
    end
  end

  // Indexed move addresses from the frame pointer.
  assign mv_src  = fp_q + {5'h00, instr_i[6:0]};
  assign mv_dst  = fp_q + {5'h00, instr_i[6:0]};
  assign dst_bad = is_ind(mv_dst) || (mv_dst == cise_pkg::PCL_ADDR)
                 || (mv_dst == cise_pkg::STACK_TOP_LOW_ADDR) || (mv_dst == cise_pkg::STACK_TOP_HIGH_ADDR)
                 || (mv_dst == cise_pkg::STACK_TOP_UPPER_ADDR);
  assign comp    = ~rd_data;

  // The decoder only accepts words in states that consume them.
  assign instr_ready_o = (state_q != cise_pkg::S_RMW);

  // Instruction sequencing and core register updates.
  always_comb begin
    state_d   = state_q;
    rmw_d     = rmw_q;
    flags_d   = flags_q;
    acc_d     = acc_q;
    bsr_d     = bsr_q;
    fp_d      = fp_q;
    addr_d    = addr_q;
    dest_d    = dest_q;
    src_ind_d = src_ind_q;
    rd_en     = 1'b0;
    rd_addr   = eff_a;
    wr_en     = 1'b0;
    wr_addr   = eff_a;
    wr_data   = 8'h00;
    wdt_clr   = 1'b0;
    unique case (state_q)
      cise_pkg::S_DEC: begin
        if (is_clear_file_op) begin
          wr_en        = 1'b1;
          flags_d.zero = 1'b1;
        end else if (is_complement_file_op || is_cpfs) begin
          rd_en   = 1'b1;
          addr_d  = eff_a;
          dest_d  = instr_i[9];
          rmw_d   = is_complement_file_op ? cise_pkg::RMW_COMPLEMENT_FILE_OP : cise_pkg::RMW_CMP;
          state_d = cise_pkg::S_RMW;
        end else if (is_movs) begin
          rd_en     = 1'b1;
          rd_addr   = mv_src;
          src_ind_d = is_ind(mv_src);
          state_d   = cise_pkg::S_WD2;
        end else if (is_push) begin
          wr_en   = 1'b1;
          wr_addr = fp_q;
          wr_data = f_fld;
          fp_d    = fp_q - 12'h001;
        end else if (is_wdt) begin
          wdt_clr           = 1'b1;
          flags_d.timeout   = 1'b1;
          flags_d.powerdown = 1'b1;
        end
      end
      cise_pkg::S_RMW: begin
        state_d = cise_pkg::S_DEC;
        if (rmw_q == cise_pkg::RMW_COMPLEMENT_FILE_OP) begin
          flags_d.neg  = comp[7];
          flags_d.zero = (comp == 8'h00);
          if (!dest_q) begin
            acc_d = comp;
          end else begin
            wr_en   = 1'b1;
            wr_addr = addr_q;
            wr_data = comp;
          end
        end else if (rd_data == acc_q) begin
          state_d = cise_pkg::S_SK1;
        end
      end
      cise_pkg::S_WD2: begin
        if (instr_valid_i) begin
          state_d = cise_pkg::S_DEC;
          wr_en   = !dst_bad;
          wr_addr = mv_dst;
          wr_data = src_ind_q ? 8'h00 : rd_data;
        end
      end
      cise_pkg::S_SK1: begin
        if (instr_valid_i) begin
          state_d = two_word(instr_i) ? cise_pkg::S_SK2 : cise_pkg::S_DEC;
        end
      end
      cise_pkg::S_SK2: begin
        if (instr_valid_i) begin
          state_d = cise_pkg::S_DEC;
        end
      end
      default: begin
        state_d = cise_pkg::S_DEC;
      end
    endcase
    // External loads take priority over the instruction's own update.
    if (load_acc_i) begin
      acc_d = load_val_i[7:0];
    end
    if (load_bsr_i) begin
      bsr_d = load_val_i[3:0];
    end
    if (load_fp_i) begin
      fp_d = load_val_i;
    end
    // Outside events clear the timeout and powerdown flags, but a watchdog-clear in the same cycle wins.
    if (timeout_clr_i && !wdt_clr) begin
      flags_d.timeout = 1'b0;
    end
    if (powerdown_clr_i && !wdt_clr) begin
      flags_d.powerdown = 1'b0;
    end
  end

  // Watchdog counter with its postscaler; clearing beats a tick.
  always_comb begin
    wdt_d  = wdt_q;
    post_d = post_q;
    if (wdt_clr) begin
      wdt_d  = '0;
      post_d = '0;
    end else if (wdt_tick_i) begin
      wdt_d = wdt_q + 1'b1;
      if (&wdt_q) begin
        post_d = post_q + 1'b1;
      end
    end
  end

  // Register stage for all state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q   <= cise_pkg::S_DEC;
      rmw_q     <= cise_pkg::RMW_COMPLEMENT_FILE_OP;
      flags_q   <= cise_pkg::FLAGS_RST;
      acc_q     <= cise_pkg::ACC_RST;
      bsr_q     <= cise_pkg::BSR_RST;
      fp_q      <= cise_pkg::FP_RST;
      addr_q    <= 12'h000;
      dest_q    <= 1'b0;
      src_ind_q <= 1'b0;
      wdt_q     <= '0;
      post_q    <= '0;
      seen_q    <= 1'b0;
      waddr_q   <= 12'h000;
      wdata_q   <= 8'h00;
    end else begin
      state_q   <= state_d;
      rmw_q     <= rmw_d;
      flags_q   <= flags_d;
      acc_q     <= acc_d;
      bsr_q     <= bsr_d;
      fp_q      <= fp_d;
      addr_q    <= addr_d;
      dest_q    <= dest_d;
      src_ind_q <= src_ind_d;
      wdt_q     <= wdt_d;
      post_q    <= post_d;
      seen_q    <= wr_en;
      waddr_q   <= wr_en ? wr_addr : waddr_q;
      wdata_q   <= wr_en ? wr_data : wdata_q;
    end
  end

  cise_dmem #(
    .AW (cise_pkg::ADDR_W),
    .DW (cise_pkg::DATA_W)
  ) u_dmem (
    .clk_i     (clk_i),
    .rd_en_i   (rd_en),
    .rd_addr_i (rd_addr),
    .rd_data_o (rd_data),
    .wr_en_i   (wr_en),
    .wr_addr_i (wr_addr),
    .wr_data_i (wr_data)
  );

  assign acc_o              = acc_q;
  assign bank_select_reg_o  = bsr_q;
  assign frame_pointer_o    = fp_q;
  assign flags_o            = flags_q;
  assign watchdog_counter_o = wdt_q;
  assign postscaler_o       = post_q;
  assign wr_seen_o          = seen_q;
  assign wr_addr_o          = waddr_q;
  assign wr_data_o          = wdata_q;

  // Checks on the executed behaviour.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_clear_file_op;
    is_clear_file_op |=> seen_q && (wdata_q == 8'h00) && flags_q.zero;
  endproperty
  a_clear_file_op: assert property (p_clear_file_op) else $error("clear-file result wrong");

  property p_bank;
    (is_clear_file_op && instr_i[8]) |=> (waddr_q == {$past(bsr_q), $past(f_fld)});
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_ext;
    (is_clear_file_op && !instr_i[8] && ext_set_en_i && (f_fld <= 8'h5F))
      |=> (waddr_q == $past(fp_q) + {4'h0, $past(f_fld)});
  endproperty
  a_ext: assert property (p_ext) else $error("indexed literal offset wrong");

  property p_complement_file_op;
    (is_complement_file_op && !instr_i[9] && !load_acc_i) ##1 !load_acc_i
      |=> (acc_q == ~$past(rd_data)) && (flags_q.neg == acc_q[7]);
  endproperty
  a_complement_file_op: assert property (p_complement_file_op) else $error("complement to accumulator wrong");

  property p_skip;
    (state_q == cise_pkg::S_RMW && rmw_q == cise_pkg::RMW_CMP && rd_data == acc_q)
      |=> (state_q == cise_pkg::S_SK1) && $stable(flags_q.neg) && $stable(flags_q.zero);
  endproperty
  a_skip: assert property (p_skip) else $error("compare skip wrong");

  property p_movs;
    is_movs |=> (state_q == cise_pkg::S_WD2) && !instr_ready_o == 1'b0;
  endproperty
  a_movs: assert property (p_movs) else $error("indexed move not two words");

  property p_guard;
    (state_q == cise_pkg::S_WD2 && instr_valid_i && dst_bad) |=> !seen_q;
  endproperty
  a_guard: assert property (p_guard) else $error("protected destination written");

  property p_srcz;
    (state_q == cise_pkg::S_WD2 && instr_valid_i && src_ind_q && !dst_bad)
      |=> seen_q && (wdata_q == 8'h00);
  endproperty
  a_srcz: assert property (p_srcz) else $error("indirect source not zero");

  property p_push;
    (is_push && !load_fp_i) |=> (fp_q == $past(fp_q) - 12'h001) && (waddr_q == $past(fp_q));
  endproperty
  a_push: assert property (p_push) else $error("literal push wrong");

  property p_wdt;
    is_wdt |=> (wdt_q == '0) && (post_q == '0) && flags_q.timeout && flags_q.powerdown;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");

  c_skip2: cover property (state_q == cise_pkg::S_SK2);
  c_push: cover property (is_push);
  c_movs: cover property (state_q == cise_pkg::S_WD2 && instr_valid_i && !dst_bad);

endmodule

// >>> test/tb_top.sv
// Self-checking testbench for the instruction subset executor.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // Design ports.
  logic                  clk_i;
  logic                  rst_i;
  logic [15:0]           instr_i;
  logic                  instr_valid_i;
  logic                  instr_ready_o;
  logic                  ext_set_en_i;
  logic                  load_acc_i;
  logic                  load_bsr_i;
  logic                  load_fp_i;
  logic [11:0]           load_val_i;
  logic                  wdt_tick_i;
  logic                  timeout_clr_i;
  logic                  powerdown_clr_i;
  logic [7:0]            acc_o;
  logic [3:0]            bank_select_reg_o;
  logic [11:0]           frame_pointer_o;
  cise_pkg::cise_flags_s flags_o;
  logic [1:0]            watchdog_counter_o;
  logic [3:0]            postscaler_o;
  logic                  wr_seen_o;
  logic [11:0]           wr_addr_o;
  logic [7:0]            wr_data_o;
  int                    error_cnt;
  int                    comparisons;
  cise_pkg::cise_flags_s saved;

  // Narrow watchdog so that a counter wrap takes only four ticks.
  cise_exec #(.WDT_W(2), .POST_W(4)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o), .ext_set_en_i(ext_set_en_i), .load_acc_i(load_acc_i),
    .load_bsr_i(load_bsr_i), .load_fp_i(load_fp_i), .load_val_i(load_val_i),
    .wdt_tick_i(wdt_tick_i), .timeout_clr_i(timeout_clr_i),
    .powerdown_clr_i(powerdown_clr_i), .acc_o(acc_o), .bank_select_reg_o(bank_select_reg_o),
    .frame_pointer_o(frame_pointer_o), .flags_o(flags_o),
    .watchdog_counter_o(watchdog_counter_o), .postscaler_o(postscaler_o),
    .wr_seen_o(wr_seen_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o));

  // Free-running 200 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Value comparison; case inequality so that an unknown never matches.
  // Wide enough for the 21-bit write echo, so no compared bit is cut off.
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Offers a word and returns 1 ns after the edge that took it; valid stays up.
  task automatic issue(input logic [15:0] w);
    int n;
    n = 0;
    instr_i = w;
    instr_valid_i = 1'b1;
    while (instr_ready_o !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 8) begin
      error_cnt++;
      $display("unexpected at %0t: word never taken", $time);
    end
    @(posedge clk_i);
    #1;
  endtask

  // Withdraws the offered word before the next edge can take it again.
  task automatic idle();
    instr_valid_i = 1'b0;
  endtask

  // One-cycle load pulse: 0 accumulator, 1 bank register, 2 frame pointer.
  task automatic load(input int sel, input logic [11:0] v);
    load_val_i = v;
    case (sel)
      0: load_acc_i = 1'b1;
      1: load_bsr_i = 1'b1;
      default: load_fp_i = 1'b1;
    endcase
    @(posedge clk_i);
    #1;
    load_acc_i = 1'b0;
    load_bsr_i = 1'b0;
    load_fp_i = 1'b0;
  endtask

  task automatic t_reset();
    chk(acc_o, 16'h0000, "acc");
    chk(frame_pointer_o, 16'h0000, "fp");
    chk(flags_o, 16'h000C, "flags");
    chk({watchdog_counter_o, postscaler_o}, 16'h0000, "counters");
    chk(instr_ready_o, 16'h0001, "ready");
    chk(bank_select_reg_o, 16'h0000, "bank reg");
    chk({wr_seen_o, wr_addr_o, wr_data_o}, 21'h000000, "write echo");
  endtask

  task automatic t_push();
    load(2, 12'h101);
    saved = flags_o;
    issue(16'hAF13);
    chk(wr_addr_o, 16'h0101, "push addr");
    chk(wr_data_o, 16'h0013, "push data");
    chk(frame_pointer_o, 16'h0100, "push fp");
    chk(flags_o, saved, "push flags");
    idle();
  endtask

  // Complement to accumulator, then back to the byte itself.
  task automatic t_complement_file_op();
    load(1, 12'h001);
    chk(bank_select_reg_o, 16'h0001, "bank load");
    issue(16'h1D01);
    idle();
    chk(instr_ready_o, 16'h0000, "complement_file_op stall");
    @(posedge clk_i);
    #1;
    chk(acc_o, 16'h00EC, "complement_file_op acc");
    chk({flags_o.neg, flags_o.zero}, 16'h0002, "complement_file_op nz");
    issue(16'h1F01);
    idle();
    @(posedge clk_i);
    #1;
    chk({wr_seen_o, wr_addr_o, wr_data_o}, 21'h1101EC, "complement_file_op file");
  endtask

  // Equal compares drop one word, or two after a two-word opcode.
  task automatic t_cpfs();
    saved = flags_o;
    issue(16'h6301);
    issue(16'hAF21);
    chk(wr_seen_o, 16'h0000, "skip one");
    issue(16'hAF22);
    chk({wr_seen_o, wr_data_o}, 16'h0122, "after skip");
    issue(16'h6301);
    issue(16'hC123);
    issue(16'hAF23);
    chk(wr_seen_o, 16'h0000, "skip two");
    issue(16'hAF24);
    chk({wr_seen_o, wr_data_o}, 16'h0124, "after skip two");
    idle();
    load(0, 12'h000);
    issue(16'h6301);
    issue(16'hAF25);
    chk({wr_seen_o, wr_data_o}, 16'h0125, "no skip");
    chk(flags_o, saved, "cmp flags");
    idle();
  endtask

  task automatic cl(input logic ext, input logic a, input logic [7:0] f, input logic [11:0] e);
    ext_set_en_i = ext;
    issue({7'h35, a, f});
    chk({wr_seen_o, wr_addr_o, wr_data_o}, {1'b1, e, 8'h00}, "clear");
    chk(flags_o.zero, 16'h0001, "clear zero");
  endtask

  // Bank, access bank and frame-relative forms, with the 5Fh boundary.
  task automatic t_clear_file_op();
    load(1, 12'h002);
    load(2, 12'h200);
    cl(1'b0, 1'b1, 8'h34, 12'h234);
    cl(1'b0, 1'b0, 8'h10, 12'h010);
    cl(1'b0, 1'b0, 8'h70, 12'hF70);
    cl(1'b1, 1'b0, 8'h10, 12'h210);
    cl(1'b1, 1'b0, 8'h5F, 12'h25F);
    cl(1'b1, 1'b0, 8'h60, 12'hF60);
    cl(1'b1, 1'b1, 8'h20, 12'h220);
    idle();
    ext_set_en_i = 1'b0;
  endtask

  task automatic mv(input logic [11:0] fp, input logic [6:0] zs, input logic [6:0] zd,
                    input logic w, input logic [11:0] ea, input logic [7:0] ed);
    idle();
    load(2, fp);
    issue({9'h1D7, zs});
    issue({9'h1E0, zd});
    chk(wr_seen_o, w, "move write");
    if (w) begin
      chk({wr_addr_o, wr_data_o}, {ea, ed}, "move result");
    end
  endtask

  // Sources are seeded by pushes, since the data memory has no reset.
  task automatic t_move();
    logic [6:0] prot [4];
    prot = '{7'h09, 7'h0D, 7'h0E, 7'h0F};
    load(2, 12'h085);
    issue(16'hAF33);
    mv(12'h080, 7'h05, 7'h06, 1'b1, 12'h086, 8'h33);
    idle();
    load(2, 12'hF85);
    issue(16'hAF5A);
    mv(12'hF80, 7'h05, 7'h10, 1'b1, 12'hF90, 8'h5A);
    mv(12'hF80, 7'h5F, 7'h10, 1'b1, 12'hF90, 8'h00);
    mv(12'hF80, 7'h05, 7'h5B, 1'b0, 12'h000, 8'h00);
    foreach (prot[i]) begin
      mv(12'hFF0, 7'h00, prot[i], 1'b0, 12'h000, 8'h00);
    end
    idle();
  endtask

  // Five ticks wrap the two-bit counter once before the clear.
  task automatic t_wdt();
    wdt_tick_i = 1'b1;
    timeout_clr_i = 1'b1;
    powerdown_clr_i = 1'b1;
    repeat (5) begin
      @(posedge clk_i);
      #1;
    end
    wdt_tick_i = 1'b0;
    timeout_clr_i = 1'b0;
    powerdown_clr_i = 1'b0;
    chk({watchdog_counter_o, postscaler_o}, 16'h0011, "ticks");
    // Negative stays set from the complement and zero from the clears.
    chk(flags_o, 16'h0003, "flags cleared");
    issue(16'h0004);
    idle();
    chk({watchdog_counter_o, postscaler_o}, 16'h0000, "wdt clear");
    chk({flags_o.timeout, flags_o.powerdown}, 16'h0003, "wdt flags");
  endtask

  task automatic summarize();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence; inputs change 1 ns after the rising edge.
  initial begin
    error_cnt = 0;
    comparisons = 0;
    rst_i = 1'b1;
    instr_i = 16'h0000;
    instr_valid_i = 1'b0;
    ext_set_en_i = 1'b0;
    load_acc_i = 1'b0;
    load_bsr_i = 1'b0;
    load_fp_i = 1'b0;
    load_val_i = 12'h000;
    wdt_tick_i = 1'b0;
    timeout_clr_i = 1'b0;
    powerdown_clr_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_push();
    t_complement_file_op();
    t_cpfs();
    t_clear_file_op();
    t_move();
    t_wdt();
    summarize();
  end

  // The tests need under a hundred cycles; far past that the run has hung.
  initial begin
    #100us;
    error_cnt++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end
endmodule
